// ---- swd_top.sv ----
`timescale 1ns/1ps
module swd_top
	import swd_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             sys_reset_o,
	output logic             nmi_o,
	output logic             irq_o
);
	logic        en, next_en;
	logic [1:0]  act, next_act;
	logic [31:0] start, next_start;
	logic [31:0] cnt, next_cnt;
	logic        fired, next_fired;
	logic        cause, next_cause;
	logic        ist, next_ist;
	logic        imsk, next_imsk;
	logic [1:0]  rst_cnt, next_rst_cnt;
	logic        nmi, next_nmi;
	logic        aw_ok, next_aw_ok, w_ok, next_w_ok;
	logic [7:0]  awa, next_awa;
	logic [31:0] wd, next_wd;
	logic [3:0]  ws, next_ws;
	logic        bv, next_bv, rv, next_rv;
	logic [1:0]  br, next_br, rr, next_rr;
	logic [31:0] rd, next_rd;
	logic        wr_go, expire;
	logic [31:0] wmask;

	assign s_axi_awready = !aw_ok && !bv;
	assign s_axi_wready  = !w_ok && !bv;
	assign s_axi_arready = !rv;
	assign s_axi_bvalid  = bv;
	assign s_axi_bresp   = br;
	assign s_axi_rvalid  = rv;
	assign s_axi_rresp   = rr;
	assign s_axi_rdata   = rd;
	assign sys_reset_o   = (rst_cnt != 2'h0);
	assign nmi_o         = nmi;
	assign irq_o         = ist && imsk;
	assign wr_go  = aw_ok && w_ok;
	assign expire = en && !fired && (cnt == 32'h0000_0000);
	assign wmask  = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};

	always_comb begin
		next_aw_ok = aw_ok;
		next_w_ok  = w_ok;
		next_awa   = awa;
		next_wd    = wd;
		next_ws    = ws;
		next_bv    = bv;
		next_br    = br;
		next_rv    = rv;
		next_rr    = rr;
		next_rd    = rd;
		next_en    = en;
		next_act   = act;
		next_start = start;
		next_cnt   = cnt;
		next_fired = fired;
		next_cause = cause;
		next_ist   = ist;
		next_imsk  = imsk;
		next_nmi   = 1'b0;
		next_rst_cnt = (rst_cnt != 2'h0) ? rst_cnt - 2'h1 : 2'h0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_ok = 1'b1;
			next_awa   = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_ok = 1'b1;
			next_wd   = s_axi_wdata;
			next_ws   = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bv = 1'b0;
		// countdown on the bus clock only
		if (en && cnt != 32'h0000_0000)
			next_cnt = cnt - 32'h0000_0001;
		if (expire) begin
			next_fired = 1'b1;
			unique case (swd_act_t'(act))
				SWD_ACT_RESET: begin
					next_rst_cnt = SWD_RESP_WIDTH;
					next_cause   = 1'b1;
				end
				SWD_ACT_NMI:  next_nmi = 1'b1;
				SWD_ACT_IRQ:  next_ist = 1'b1;
				SWD_ACT_NONE: next_fired = 1'b1;
			endcase
		end
		if (wr_go) begin
			next_aw_ok = 1'b0;
			next_w_ok  = 1'b0;
			next_bv    = 1'b1;
			next_br    = 2'b00;
			unique case (awa)
				SWD_OFS_CTRL: begin
					if (ws[0]) begin
						next_en  = wd[SWD_CTRL_EN];
						next_act = wd[SWD_CTRL_ACT +: 2];
						// writing one clears the cause flag, unless the counter expires in the same cycle
						if (wd[SWD_CTRL_CAUSE] && !expire)
							next_cause = 1'b0;
						if (!wd[SWD_CTRL_EN])
							next_fired = 1'b0;
						if (wd[SWD_CTRL_EN] && !en) begin
							next_cnt   = start;
							next_fired = 1'b0;
						end
					end
				end
				SWD_OFS_COUNT:
					next_start = (start & ~wmask) | (wd & wmask);
				SWD_OFS_RELOAD: begin
					next_cnt   = start;
					next_fired = 1'b0;
				end
				SWD_OFS_IRQST:
					if (ws[0] && wd[0] && !next_ist_set(expire, act))
						next_ist = 1'b0;
				SWD_OFS_IRQMSK:
					if (ws[0])
						next_imsk = wd[0];
				default: next_br = 2'b10;
			endcase
		end
		if (s_axi_rready && rv)
			next_rv = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rv = 1'b1;
			next_rr = 2'b00;
			unique case (s_axi_araddr)
				SWD_OFS_CTRL:   next_rd = {28'h000_0000, cause, act, en};
				SWD_OFS_COUNT:  next_rd = start;
				SWD_OFS_STAT:   next_rd = cnt;
				SWD_OFS_IRQST:  next_rd = {31'h0000_0000, ist};
				SWD_OFS_IRQMSK: next_rd = {31'h0000_0000, imsk};
				SWD_OFS_RELOAD: next_rd = 32'h0000_0000;
				default: begin
					next_rd = 32'h0000_0000;
					next_rr = 2'b10;
				end
			endcase
		end
	end

	function automatic logic next_ist_set(input logic ex,
		input logic [1:0] a);
		next_ist_set = ex && (a == SWD_ACT_IRQ);
	endfunction : next_ist_set

	// the cause flag has its own block but clears on rst_i, the same reset as the config
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			cause <= 1'b0;
		else
			cause <= next_cause;
	end

	// sys_reset_o is not looped back here: the config clears on rst_i only,
	// so a system that wants it cleared must route its reset to rst_i
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			en <= 1'b0;
			act <= 2'b00;
			start <= SWD_COUNT_RST;
			cnt <= SWD_COUNT_RST;
			fired <= 1'b0;
			ist <= 1'b0;
			imsk <= 1'b0;
			rst_cnt <= 2'h0;
			nmi <= 1'b0;
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			awa <= 8'h00;
			wd <= 32'h0000_0000;
			ws <= 4'h0;
			bv <= 1'b0;
			br <= 2'b00;
			rv <= 1'b0;
			rr <= 2'b00;
			rd <= 32'h0000_0000;
		end else begin
			en <= next_en;
			act <= next_act;
			start <= next_start;
			cnt <= next_cnt;
			fired <= next_fired;
			ist <= next_ist;
			imsk <= next_imsk;
			rst_cnt <= next_rst_cnt;
			nmi <= next_nmi;
			aw_ok <= next_aw_ok;
			w_ok <= next_w_ok;
			awa <= next_awa;
			wd <= next_wd;
			ws <= next_ws;
			bv <= next_bv;
			br <= next_br;
			rv <= next_rv;
			rr <= next_rr;
			rd <= next_rd;
		end
	end

	a_count_down: assert property (
		@(posedge clock_i) disable iff (rst_i)
		en && cnt != 32'h0000_0000 && !wr_go
		|=> cnt == $past(cnt) - 32'h0000_0001)
		else $error("counter did not decrement");
	a_expire_nmi: assert property (
		@(posedge clock_i) disable iff (rst_i)
		expire && act == SWD_ACT_NMI |=> nmi_o ##1 !nmi_o)
		else $error("nmi not a single pulse");
	a_expire_rst: assert property (
		@(posedge clock_i) disable iff (rst_i)
		expire && act == SWD_ACT_RESET
		|=> sys_reset_o [*3] ##1 !sys_reset_o)
		else $error("reset pulse wrong length");
	a_cause_set: assert property (
		@(posedge clock_i) disable iff (rst_i)
		expire && act == SWD_ACT_RESET |=> cause)
		else $error("cause flag not set");
	a_fire_once: assert property (
		@(posedge clock_i) disable iff (rst_i)
		fired && !wr_go |=> !expire && !nmi_o)
		else $error("response repeated");
	a_hold_zero: assert property (
		@(posedge clock_i) disable iff (rst_i)
		fired && cnt == 32'h0000_0000 && !wr_go
		|=> cnt == 32'h0000_0000)
		else $error("counter left zero");
	a_load_start: assert property (
		@(posedge clock_i) disable iff (rst_i)
		wr_go && awa == SWD_OFS_RELOAD |=> cnt == $past(start))
		else $error("reload value wrong");
	a_irq_level: assert property (
		@(posedge clock_i) disable iff (rst_i)
		expire && act == SWD_ACT_IRQ && imsk && !wr_go |=> irq_o)
		else $error("irq missing");
endmodule : swd_top

// ---- swd_pkg.sv ----
// Behaviour
// - 32-bit counter loaded from programmed start count
// - expiry raises selected reset, NMI or interrupt
// - counts down; reload restarts from programmed value
// - reset response resets core and all peripherals (sys_reset_o is not looped back: this block's config clears on rst_i only)
// - status bit survives watchdog reset, shows cause (cause clears on rst_i, the same reset as the config)
// - counter decrements on system bus clock
package swd_pkg;
	localparam logic [7:0]  SWD_OFS_CTRL   = 8'h00;
	localparam logic [7:0]  SWD_OFS_COUNT  = 8'h04;
	localparam logic [7:0]  SWD_OFS_STAT   = 8'h08;
	localparam logic [7:0]  SWD_OFS_IRQST  = 8'h0C;
	localparam logic [7:0]  SWD_OFS_IRQMSK = 8'h10;
	localparam logic [7:0]  SWD_OFS_RELOAD = 8'h14;
	localparam int          SWD_CTRL_EN    = 0;
	localparam int          SWD_CTRL_ACT   = 1;
	localparam int          SWD_CTRL_CAUSE = 3;
	localparam logic [31:0] SWD_COUNT_RST  = 32'hFFFF_FFFF;
	localparam logic [1:0]  SWD_RESP_WIDTH = 2'h3;
	typedef enum logic [1:0] {
		SWD_ACT_NONE  = 2'b00,
		SWD_ACT_RESET = 2'b01,
		SWD_ACT_NMI   = 2'b10,
		SWD_ACT_IRQ   = 2'b11
	} swd_act_t;
endpackage : swd_pkg

// ---- tb.sv ----
`timescale 1ns/1ps
module tb
	import swd_pkg::*;
();
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        sys_reset_o, nmi_o, irq_o;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          miscompares = 0, cmp_count = 0, cyc = 0;
	int          n_rst = 0, n_nmi = 0;

	swd_top swd_top_i (.clock_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sys_reset_o,
		.nmi_o, .irq_o);

	always #5 clock_i = ~clock_i;

	// counts high cycles, so pulse width and repeats both show up
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		n_rst <= n_rst + int'(sys_reset_o);
		n_nmi <= n_nmi + int'(nmi_o);
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			close_out();
		end
	end

	task automatic close_out();
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task automatic chk(input string n, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// ready is combinational: look at it at the falling edge, before
	// the rising edge that takes the item can move it
	// bready and rready stay high once raised: dropping them at the end
	// of one call and raising them in the next would drive them twice
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tbr;
		logic [1:0] rb;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tbr = 1'b0;
		while (!tbr) begin
			@(negedge clock_i);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tbr = s_axi_bvalid;
			rb = s_axi_bresp;
			@(posedge clock_i);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		chk("bresp", 32'h0, {30'h0, rb});
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rr);
		logic ta, tr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clock_i);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			v = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clock_i);
			if (ta) s_axi_arvalid <= 1'b0;
		end
	endtask : rd

	task automatic rc(input string n, input logic [7:0] a,
		input logic [31:0] e);
		rd(a, d, r);
		chk(n, e, d);
		chk("rresp", 32'h0, {30'h0, r});
	endtask : rc

	task automatic ck_irq(input logic e);
		repeat (2) @(negedge clock_i);
		chk("irq", {31'h0, e}, {31'h0, irq_o});
		@(posedge clock_i);
	endtask : ck_irq

	// short start count keeps the run brief
	task automatic expire(input logic [1:0] act);
		wr(SWD_OFS_COUNT, 32'h8);
		wr(SWD_OFS_CTRL, {29'h0, act, 1'b0});
		wr(SWD_OFS_CTRL, {29'h0, act, 1'b1});
		d = 32'h1;
		for (int i = 0; i < 20 && d !== 32'h0; i++)
			rd(SWD_OFS_STAT, d, r);
		chk("count zero", 32'h0, d);
		repeat (20) @(posedge clock_i);
		rc("count held", SWD_OFS_STAT, 32'h0);
	endtask : expire

	initial begin
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		rc("ctrl", SWD_OFS_CTRL, 32'h0);
		rc("start", SWD_OFS_COUNT, SWD_COUNT_RST);
		rd(8'h18, d, r);
		chk("bad rresp", 32'h2, {30'h0, r});
		chk("bad rdata", 32'h0, d);
		// only lane 0 of the start count may change here
		s_axi_wstrb <= 4'h1;
		wr(SWD_OFS_COUNT, 32'h0000_0055);
		s_axi_wstrb <= 4'hF;
		rc("start lane", SWD_OFS_COUNT, 32'hFFFF_FF55);
		expire(SWD_ACT_RESET);
		chk("reset cycles", 32'd3, n_rst);
		rc("cause", SWD_OFS_CTRL, 32'hB);
		wr(SWD_OFS_CTRL, 32'h8);
		rc("cause clr", SWD_OFS_CTRL, 32'h0);
		expire(SWD_ACT_NMI);
		chk("nmi cycles", 32'd1, n_nmi);
		wr(SWD_OFS_CTRL, 32'h0);
		expire(SWD_ACT_IRQ);
		ck_irq(1'b0);
		rc("irq status", SWD_OFS_IRQST, 32'h1);
		wr(SWD_OFS_IRQMSK, 32'h1);
		ck_irq(1'b1);
		wr(SWD_OFS_IRQST, 32'h1);
		ck_irq(1'b0);
		wr(SWD_OFS_CTRL, 32'h0);
		expire(SWD_ACT_IRQ);
		ck_irq(1'b1);
		wr(SWD_OFS_CTRL, 32'h0);
		wr(SWD_OFS_COUNT, 32'h10);
		wr(SWD_OFS_CTRL, 32'h2);
		wr(SWD_OFS_CTRL, 32'h3);
		repeat (8) wr(SWD_OFS_RELOAD, 32'h0);
		chk("no early reset", 32'd3, n_rst);
		repeat (40) @(posedge clock_i);
		chk("late reset", 32'd6, n_rst);
		close_out();
	end
endmodule : tb
